// File: verilog/swf_core.sv
`timescale 1ns/1ns
module swf_core #(
  parameter int WD_CYCLES = swf_pkg::WD_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        wake,
  input  wire logic        active_low_reset_input,
  input  wire logic        watchdog_toggle_pin,
  input  wire logic        failsafe_disable_input,
  input  wire logic        chip_select_low_active,
  input  wire logic        lowside_direct_input,
  input  wire logic [3:0]  highside_direct_inputs,
  input  wire logic [11:0] over_temp_sense,
  input  wire logic [11:0] open_load_sense,
  input  wire logic [7:0]  drain_high_sense,
  input  wire logic        over_voltage_sense,
  input  wire logic        msg_valid,
  input  wire logic [2:0]  msg_addr,
  input  wire logic [15:0] msg_data,
  output logic      [11:0] output_on,
  output logic      [11:0] output_fault_bits,
  output logic             fault_pin_low_active,
  output logic      [1:0]  mode
);

  localparam int NS = 43;

  logic [NS-1:0] pins_s;
  logic          wake_s, rst_n_s, wdp_s, fsi_s, cs_s, ils_s, ov_s;
  logic [3:0]    ihs_s;
  logic [11:0]   ot_s, ol_s;
  logic [7:0]    dh_s;

  swf_sync #(.WIDTH(NS)) u_sync (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .async_in ({wake, active_low_reset_input, watchdog_toggle_pin,
                failsafe_disable_input, ~chip_select_low_active,
                lowside_direct_input, highside_direct_inputs,
                over_temp_sense, open_load_sense, drain_high_sense,
                over_voltage_sense}),
    .sync_out (pins_s)
  );

  assign {wake_s, rst_n_s, wdp_s, fsi_s, cs_s, ils_s, ihs_s,
          ot_s, ol_s, dh_s, ov_s} = pins_s;

  // edge history; chip select enters inverted so reset matches its idle
  logic wake_p_q, rst_p_q, wdp_p_q, cs_p_q;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wake_p_q <= 1'b0;
      rst_p_q  <= 1'b0;
      wdp_p_q  <= 1'b0;
      cs_p_q   <= 1'b0;
    end else begin
      wake_p_q <= wake_s;
      rst_p_q  <= rst_n_s;
      wdp_p_q  <= wdp_s;
      cs_p_q   <= cs_s;
    end
  end

  logic wake_rise, rst_rise, cs_rise;
  assign wake_rise = wake_s & ~wake_p_q;
  assign rst_rise  = rst_n_s & ~rst_p_q;
  assign cs_rise   = ~cs_s & cs_p_q;

  // configuration, forced to defaults while reset pin is low
  logic [11:0] out_cmd_q, direct_q, open_load_config_q;
  logic [11:0] current_limit_config_q;
  logic [1:0]  watchdog_sense_config_q;
  logic        wd_bit_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst || !rst_n_s) begin
      out_cmd_q               <= swf_pkg::CFG_RESET;
      direct_q                <= swf_pkg::CFG_RESET;
      open_load_config_q      <= swf_pkg::CFG_RESET;
      current_limit_config_q  <= swf_pkg::CFG_RESET;
      watchdog_sense_config_q <= swf_pkg::DIV_RESET;
    end else if (msg_valid) begin
      case (msg_addr)
        swf_pkg::ADDR_OUT_CMD:   out_cmd_q <= msg_data[11:0];
        swf_pkg::ADDR_DIRECT:    direct_q  <= msg_data[11:0];
        swf_pkg::ADDR_OPEN_LOAD: open_load_config_q <= msg_data[11:0];
        swf_pkg::ADDR_CUR_LIMIT: current_limit_config_q <= msg_data[11:0];
        swf_pkg::ADDR_WD_SENSE: begin
          watchdog_sense_config_q <=
            msg_data[swf_pkg::WD_DIV_HI:swf_pkg::WD_DIV_LO];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wd_bit_q <= 1'b0;
    end else if (msg_valid) begin
      wd_bit_q <= msg_data[swf_pkg::WD_MSG_BIT];
    end
  end

  logic wd_toggle;
  assign wd_toggle = (wdp_s ^ wdp_p_q) |
                     (msg_valid & (msg_data[swf_pkg::WD_MSG_BIT] ^ wd_bit_q));

  // watchdog
  swf_pkg::swf_mode_t mode_q, mode_d;
  logic                      wd_en_q, wake_seen_q, wd_expire;
  logic [swf_pkg::WD_CNT_W-1:0] wd_cnt_q, wd_limit;

  assign wd_limit = swf_pkg::WD_CNT_W'(WD_CYCLES) >> watchdog_sense_config_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wd_en_q <= 1'b0;
    end else if (!fsi_s) begin
      wd_en_q <= 1'b0;
    end else if (wake_rise || rst_rise) begin
      wd_en_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wd_cnt_q <= '0;
    end else if (wake_rise || rst_rise || wd_toggle ||
                 mode_q == swf_pkg::SWF_FAILSAFE ||
                 mode_q == swf_pkg::SWF_SLEEP) begin
      wd_cnt_q <= '0;
    end else if (wd_en_q && wd_cnt_q < wd_limit) begin
      wd_cnt_q <= wd_cnt_q + 1'b1;
    end
  end

  assign wd_expire = wd_en_q & fsi_s & (wd_cnt_q >= wd_limit) &
                     ~wd_toggle;

  // a wake seen while awake forces both pins low to leave failsafe
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wake_seen_q <= 1'b0;
    end else if (mode_q == swf_pkg::SWF_FAILSAFE &&
                 mode_d != swf_pkg::SWF_FAILSAFE) begin
      wake_seen_q <= 1'b0;
    end else if (wake_s && (mode_q == swf_pkg::SWF_NORMAL ||
                            mode_q == swf_pkg::SWF_STANDBY)) begin
      wake_seen_q <= 1'b1;
    end
  end

  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      swf_pkg::SWF_SLEEP: begin
        if (rst_n_s) begin
          mode_d = swf_pkg::SWF_NORMAL;
        end else if (wake_s) begin
          mode_d = swf_pkg::SWF_STANDBY;
        end
      end
      swf_pkg::SWF_STANDBY: begin
        if (wd_expire) begin
          mode_d = swf_pkg::SWF_FAILSAFE;
        end else if (rst_n_s) begin
          mode_d = swf_pkg::SWF_NORMAL;
        end else if (!wake_s) begin
          mode_d = swf_pkg::SWF_SLEEP;
        end
      end
      swf_pkg::SWF_NORMAL: begin
        if (wd_expire) begin
          mode_d = swf_pkg::SWF_FAILSAFE;
        end else if (!rst_n_s) begin
          mode_d = wake_s ? swf_pkg::SWF_STANDBY : swf_pkg::SWF_SLEEP;
        end
      end
      swf_pkg::SWF_FAILSAFE: begin
        if (!rst_n_s && (!wake_s || !wake_seen_q)) begin
          mode_d = wake_s ? swf_pkg::SWF_STANDBY : swf_pkg::SWF_SLEEP;
        end
      end
      default: mode_d = swf_pkg::SWF_SLEEP;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mode_q <= swf_pkg::SWF_SLEEP;
      mode   <= swf_pkg::SWF_SLEEP;
    end else begin
      mode_q <= mode_d;
      mode   <= mode_d;
    end
  end

  // per-output command and fault logic
  logic [11:0] cmd, cmd_p_q, ot_ev, ol_ev, oc_ev, hs_cut, ls_off_q;
  logic [11:0] drive_d;

  genvar gi;
  generate
    for (gi = 0; gi < swf_pkg::NUM_OUT; gi++) begin : g_out
      logic direct_in;
      if (gi < swf_pkg::NUM_HS) begin : g_hs
        assign direct_in = ihs_s[gi];
        assign ol_ev[gi] = ol_s[gi] & ~output_on[gi] &
                           ~open_load_config_q[gi];
        assign oc_ev[gi] = 1'b0;
        assign hs_cut[gi] = ot_s[gi];
        assign ls_off_q[gi] = 1'b0;
      end else begin : g_ls
        logic                          cond, occ_en;
        logic [swf_pkg::FILT_CNT_W-1:0] filt_q;
        logic                          off_q;
        assign direct_in = ils_s;
        assign occ_en = current_limit_config_q[gi];
        assign cond = output_on[gi] ? (dh_s[gi-swf_pkg::NUM_HS] & occ_en)
                                    : (ol_s[gi] & open_load_config_q[gi]);
        always_ff @(posedge clk_sys) begin
          if (sys_rst || !cond || (output_on[gi] != drive_d[gi])) begin
            filt_q <= '0;
          end else if (filt_q < swf_pkg::FILT_CNT_W'(swf_pkg::FILT_CYCLES)) begin
            filt_q <= filt_q + 1'b1;
          end
        end
        wire done = filt_q == swf_pkg::FILT_CNT_W'(swf_pkg::FILT_CYCLES);
        assign ol_ev[gi] = done & ~output_on[gi];
        assign oc_ev[gi] = done & output_on[gi];
        // latched off until the output's command is off and its over-temperature sense is clear
        always_ff @(posedge clk_sys) begin
          if (sys_rst) begin
            off_q <= 1'b0;
          end else if (ot_ev[gi] || oc_ev[gi]) begin
            off_q <= 1'b1;
          end else if (!cmd[gi] && !ot_s[gi]) begin
            off_q <= 1'b0;
          end
        end
        assign ls_off_q[gi] = off_q;
        assign hs_cut[gi] = 1'b0;
      end
      assign cmd[gi] = direct_q[gi] ? out_cmd_q[gi]
                                    : (out_cmd_q[gi] | direct_in);
      assign ot_ev[gi] = ot_s[gi] & output_on[gi];
    end
  endgenerate

  always_comb begin
    drive_d = '0;
    case (mode_q)
      swf_pkg::SWF_NORMAL: begin
        if (!ov_s) begin
          drive_d = cmd & ~hs_cut & ~ls_off_q;
        end
      end
      swf_pkg::SWF_FAILSAFE: drive_d = 12'h005;
      default: drive_d = '0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      output_on <= '0;
      cmd_p_q   <= '0;
    end else begin
      output_on <= drive_d;
      cmd_p_q   <= cmd;
    end
  end

  // status word: set beats the chip-select clear
  logic [11:0] fault_now;
  assign fault_now = ot_ev | ol_ev | oc_ev | {12{ov_s}};

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      output_fault_bits <= '0;
    end else begin
      output_fault_bits <= fault_now |
                           (output_fault_bits & ~{12{cs_rise}});
    end
  end

  // low-side part of the fault pin latches; the rest is real time
  logic [7:0] flt_ls_q;
  logic [7:0] ls_ev, ls_tog;
  assign ls_ev  = ot_ev[11:4] | ol_ev[11:4] | oc_ev[11:4];
  assign ls_tog = cmd[11:4] ^ cmd_p_q[11:4];

  always_ff @(posedge clk_sys) begin
    if (sys_rst || !rst_n_s) begin
      flt_ls_q <= '0;
    end else begin
      flt_ls_q <= ls_ev | (flt_ls_q & ~ls_tog);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fault_pin_low_active <= 1'b1;
    end else begin
      fault_pin_low_active <= ~(ov_s | (|(ot_s[3:0] & output_on[3:0])) |
                                (|ol_ev[3:0]) | (|ls_ev) |
                                (|flt_ls_q));
    end
  end

endmodule

// File: verilog/swf_pkg.sv
package swf_pkg;

  localparam int NUM_HS  = 4;
  localparam int NUM_LS  = 8;
  localparam int NUM_OUT = 12;

  // serial message layout
  localparam int MSG_W        = 16;
  localparam int MSG_ADDR_W   = 3;
  localparam int WD_MSG_BIT   = 15;
  localparam int WD_DIV_LO    = 4;
  localparam int WD_DIV_HI    = 5;

  localparam logic [2:0] ADDR_OUT_CMD   = 3'h0;
  localparam logic [2:0] ADDR_DIRECT    = 3'h1;
  localparam logic [2:0] ADDR_WD_SENSE  = 3'h3;
  localparam logic [2:0] ADDR_OPEN_LOAD = 3'h4;
  localparam logic [2:0] ADDR_CUR_LIMIT = 3'h5;

  localparam logic [11:0] CFG_RESET = 12'h000;
  localparam logic [1:0]  DIV_RESET = 2'h0;

  // timing
  localparam int CLK_MHZ        = 125;
  localparam int WD_TIMEOUT_US  = 100;
  localparam int WD_CYCLES      = WD_TIMEOUT_US * CLK_MHZ;
  localparam int FILT_NS        = 10000;
  localparam int FILT_CYCLES    = (FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int WD_CNT_W       = 24;
  localparam int FILT_CNT_W     = 12;

  typedef enum logic [1:0] {
    SWF_SLEEP    = 2'b00,
    SWF_STANDBY  = 2'b01,
    SWF_NORMAL   = 2'b10,
    SWF_FAILSAFE = 2'b11
  } swf_mode_t;

endpackage

// File: verilog/swf_sync.sv
`timescale 1ns/1ns
module swf_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // first stage feeds only the second stage
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// File: tb/swf_checker.sv
`timescale 1ns/1ns
module swf_checker #(
  parameter int WD_CYCLES = 200
) (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        watchdog_toggle_pin,
  input wire logic        failsafe_disable_input,
  input wire logic        chip_select_low_active,
  input wire logic [11:0] over_temp_sense,
  input wire logic        over_voltage_sense,
  input wire logic        msg_valid,
  input wire logic [11:0] output_on,
  input wire logic [11:0] output_fault_bits,
  input wire logic        fault_pin_low_active,
  input wire logic [1:0]  mode
);
  localparam logic [1:0] FS = swf_pkg::SWF_FAILSAFE;
  logic [15:0] idle_q;
  logic        pin_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge clk_sys) begin
    pin_q <= watchdog_toggle_pin;
  end
  // restarts earlier than the design's count; the slack covers the syncs
  always_ff @(posedge clk_sys) begin
    if (sys_rst || mode != swf_pkg::SWF_NORMAL || msg_valid ||
        !failsafe_disable_input || pin_q != watchdog_toggle_pin) begin
      idle_q <= 16'h0;
    end else begin
      idle_q <= idle_q + 16'h1;
    end
  end
  a_fs_outputs: assert property (
    (mode == FS) [*2] |-> output_on == 12'h005)
    else $error("failsafe outputs wrong");
  a_quiet_off: assert property (
    (mode == 2'h0 || mode == 2'h1) [*2] |-> output_on == 12'h000)
    else $error("outputs on in sleep or standby");
  a_ov_outputs: assert property (
    over_voltage_sense [*6] |-> output_on == 12'h000 &&
    output_fault_bits == 12'hfff)
    else $error("over-voltage response wrong");
  a_ov_fault_pin: assert property (
    over_voltage_sense [*6] |-> !fault_pin_low_active)
    else $error("fault pin high during over-voltage");
  a_wd_disabled: assert property (
    !failsafe_disable_input [*8] ##1 mode != FS |=> mode != FS)
    else $error("failsafe entered with watchdog disabled");
  a_status_hold: assert property (
    $stable(chip_select_low_active) [*6] |->
    ($past(output_fault_bits) & ~output_fault_bits) == 12'h000)
    else $error("status bit cleared without chip-select rise");
  a_wd_expiry: assert property (
    mode == swf_pkg::SWF_NORMAL |-> idle_q <= 16'(WD_CYCLES + 8))
    else $error("watchdog timeout missed");
  a_hs_thermal: assert property (
    over_temp_sense[1] [*6] |-> !output_on[1])
    else $error("hot output left on");
endmodule
bind swf_core swf_checker #(.WD_CYCLES(WD_CYCLES)) u_chk (
  .clk_sys, .sys_rst, .watchdog_toggle_pin, .failsafe_disable_input,
  .chip_select_low_active, .over_temp_sense, .over_voltage_sense,
  .msg_valid, .output_on, .output_fault_bits, .fault_pin_low_active,
  .mode);

// File: tb/swf_host_model.sv
`timescale 1ns/1ns
module swf_host_model (
  input  wire logic        clk_sys,
  output logic             msg_valid,
  output logic [2:0]       msg_addr,
  output logic [15:0]      msg_data,
  output logic             watchdog_toggle_pin,
  output logic             chip_select_low_active
);
  logic wd_bit_q = 1'b0;
  initial begin
    msg_valid = 1'b0;
    msg_addr = 3'h7;
    msg_data = 16'h0000;
    watchdog_toggle_pin = 1'b0;
    chip_select_low_active = 1'b1;
  end
  task automatic send(input logic [2:0] a, input logic [11:0] d);
    @(negedge clk_sys);
    wd_bit_q = ~wd_bit_q; // every message flips the watchdog bit
    msg_valid = 1'b1;
    msg_addr = a;
    msg_data = {wd_bit_q, 3'h0, d};
    @(negedge clk_sys);
    msg_valid = 1'b0;
    // idle bus never repeats the last word
    msg_addr = ~a;
    msg_data = ~msg_data;
  endtask
  task automatic kick();
    @(negedge clk_sys);
    watchdog_toggle_pin = ~watchdog_toggle_pin;
  endtask
  task automatic pulse_cs();
    @(negedge clk_sys);
    chip_select_low_active = 1'b0;
    repeat (2) @(negedge clk_sys);
    chip_select_low_active = 1'b1;
    repeat (8) @(negedge clk_sys);
  endtask
endmodule

// File: tb/swf_core_tb_top.sv
`timescale 1ns/1ns
module swf_core_tb_top;
  typedef struct {
    logic [2:0]  a;
    logic [11:0] d;
    logic [3:0]  hs;
    logic        ls;
    logic [11:0] exp;
  } swf_row_t;
  logic        clk_sys;
  logic        sys_rst;
  logic        wake;
  logic        active_low_reset_input;
  logic        failsafe_disable_input;
  logic        lowside_direct_input;
  logic [3:0]  highside_direct_inputs;
  logic [11:0] over_temp_sense;
  logic [11:0] open_load_sense;
  logic [7:0]  drain_high_sense;
  logic        over_voltage_sense;
  logic        msg_valid;
  logic [2:0]  msg_addr;
  logic [15:0] msg_data;
  logic        watchdog_toggle_pin;
  logic        chip_select_low_active;
  logic [11:0] output_on;
  logic [11:0] output_fault_bits;
  logic        fault_pin_low_active;
  logic [1:0]  mode;
  int          fails = 0;
  int          n_checks = 0;
  swf_row_t    rows [4] = '{'{3'h0, 12'h000, 4'h5, 1'b1, 12'hff5},
                            '{3'h0, 12'ha02, 4'h0, 1'b0, 12'ha02},
                            '{3'h1, 12'hfff, 4'hf, 1'b1, 12'ha02},
                            '{3'h1, 12'h000, 4'h8, 1'b0, 12'ha0a}};
  swf_host_model u_host (.clk_sys, .msg_valid, .msg_addr, .msg_data,
    .watchdog_toggle_pin, .chip_select_low_active);
  swf_core #(.WD_CYCLES(200)) u_dut (.clk_sys, .sys_rst, .wake,
    .active_low_reset_input, .watchdog_toggle_pin, .failsafe_disable_input,
    .chip_select_low_active, .lowside_direct_input, .highside_direct_inputs,
    .over_temp_sense, .open_load_sense, .drain_high_sense,
    .over_voltage_sense, .msg_valid, .msg_addr, .msg_data, .output_on,
    .output_fault_bits, .fault_pin_low_active, .mode);
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic step(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic chk(input string nm, input logic [11:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    conclude();
  end
  initial begin
    sys_rst = 1'b1;
    wake = 1'b0;
    active_low_reset_input = 1'b0;
    failsafe_disable_input = 1'b1;
    lowside_direct_input = 1'b0;
    highside_direct_inputs = 4'h0;
    over_temp_sense = 12'h000;
    open_load_sense = 12'h000;
    drain_high_sense = 8'h00;
    over_voltage_sense = 1'b0;
    step(5);
    sys_rst = 1'b0;
    step(4);
    chk("mode", {10'h0, mode}, 12'h000);
    chk("on", output_on, 12'h000);
    chk("pin", {11'h0, fault_pin_low_active}, 12'h001);
    active_low_reset_input = 1'b1;
    step(8);
    chk("mode", {10'h0, mode}, 12'h002);
    $display("reset test done");
    foreach (rows[i]) begin
      highside_direct_inputs = rows[i].hs;
      lowside_direct_input = rows[i].ls;
      u_host.send(rows[i].a, rows[i].d);
      step(8);
      chk("on", output_on, rows[i].exp);
    end
    $display("table test done");
    highside_direct_inputs = 4'h0;
    step(150);
    u_host.kick();
    step(150);
    chk("mode", {10'h0, mode}, 12'h002);
    step(220);
    chk("mode", {10'h0, mode}, 12'h003);
    chk("on", output_on, 12'h005);
    active_low_reset_input = 1'b0;
    step(8);
    chk("mode", {10'h0, mode}, 12'h000);
    active_low_reset_input = 1'b1;
    step(150);
    chk("mode", {10'h0, mode}, 12'h002);
    chk("on", output_on, 12'h000);
    failsafe_disable_input = 1'b0;
    step(300);
    chk("mode", {10'h0, mode}, 12'h002);
    $display("watchdog test done");
    u_host.send(3'h0, 12'h012);
    step(8);
    over_temp_sense = 12'h01a;
    step(8);
    chk("on", output_on, 12'h000);
    chk("flt", output_fault_bits, 12'h012);
    over_temp_sense = 12'h000;
    step(8);
    chk("on", output_on, 12'h002);
    chk("pin", {11'h0, fault_pin_low_active}, 12'h000);
    u_host.send(3'h0, 12'h002);
    u_host.send(3'h0, 12'h012);
    step(8);
    chk("on", output_on, 12'h012);
    chk("pin", {11'h0, fault_pin_low_active}, 12'h001);
    u_host.pulse_cs();
    chk("flt", output_fault_bits, 12'h000);
    $display("thermal test done");
    u_host.send(3'h0, 12'h000);
    open_load_sense = 12'h022;
    step(8);
    chk("flt", output_fault_bits, 12'h002);
    chk("pin", {11'h0, fault_pin_low_active}, 12'h000);
    u_host.send(3'h4, 12'h022);
    u_host.pulse_cs();
    step(1000);
    chk("flt", output_fault_bits, 12'h000);
    step(300);
    chk("flt", output_fault_bits, 12'h020);
    open_load_sense = 12'h000;
    over_voltage_sense = 1'b1;
    step(8);
    chk("flt", output_fault_bits, 12'hfff);
    over_voltage_sense = 1'b0;
    step(8);
    u_host.pulse_cs();
    chk("flt", output_fault_bits, 12'h000);
    $display("open-load and over-voltage test done");
    u_host.send(3'h5, 12'h010);
    u_host.send(3'h0, 12'h030);
    drain_high_sense = 8'h03;
    step(1000);
    chk("on", output_on, 12'h030);
    step(300);
    chk("on", output_on, 12'h020);
    chk("flt", output_fault_bits, 12'h010);
    drain_high_sense = 8'h00;
    step(8);
    chk("on", output_on, 12'h020);
    u_host.send(3'h0, 12'h000);
    u_host.send(3'h0, 12'h010);
    step(8);
    chk("on", output_on, 12'h010);
    $display("over-current test done");
    sys_rst = 1'b1;
    step(3);
    chk("mode", {10'h0, mode}, 12'h000);
    chk("on", output_on, 12'h000);
    chk("flt", output_fault_bits, 12'h000);
    sys_rst = 1'b0;
    step(8);
    chk("mode", {10'h0, mode}, 12'h002);
    chk("on", output_on, 12'h000);
    chk("pin", {11'h0, fault_pin_low_active}, 12'h001);
    $display("mid-run reset test done");
    active_low_reset_input = 1'b0;
    step(8);
    chk("mode", {10'h0, mode}, 12'h000);
    failsafe_disable_input = 1'b1;
    wake = 1'b1;
    step(8);
    chk("mode", {10'h0, mode}, 12'h001);
    chk("on", output_on, 12'h000);
    active_low_reset_input = 1'b1;
    step(8);
    chk("mode", {10'h0, mode}, 12'h002);
    u_host.send(3'h3, 12'h010);
    step(60);
    chk("mode", {10'h0, mode}, 12'h002);
    step(60);
    chk("mode", {10'h0, mode}, 12'h003);
    active_low_reset_input = 1'b0;
    step(8);
    chk("mode", {10'h0, mode}, 12'h003);
    chk("on", output_on, 12'h005);
    wake = 1'b0;
    step(8);
    chk("mode", {10'h0, mode}, 12'h000);
    $display("wake and divider test done");
    conclude();
  end
endmodule
